/* irq_ctrl_params.svh */
// Register map, field positions, reset values and sizes of the interrupt controller
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets inside the register window (PADDR[31:9] == 0); OFS_EXIT is an offset inside the vector table page
// ----------------------------------------------------------------------------
`define OFS_CONTROL      9'h000
`define OFS_PRIORITY     9'h004
`define OFS_ENC_PRIO     9'h008
`define OFS_ENC_SRC      9'h00c
`define OFS_VEC_BASE     9'h010
`define OFS_STANDBY      9'h014
`define OFS_NODE_BASE    9'h100
`define OFS_EXIT         9'h100

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_GLOBAL_EN    7
`define BIT_TABLE_EN     6
`define BIT_STANDBY_EN   0
`define BIT_NODE_MODIFY  7
`define BIT_NODE_PEND    6
`define BIT_NODE_EN      5
`define VEC_BASE_LSBS    9

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define VEC_BASE_RST     32'h0000_0200
`define NODES_DEF        40
`define NODE_STEP        8
`define MAX_NODES        64
`define STACK_DEPTH_DEF  16
`define VEC_WORDS        64

`endif

/* irq_ctrl_pkg.sv */
// Types shared by the interrupt controller files
package irq_ctrl_pkg;

  typedef logic [3:0]  prio_t;
  typedef logic [5:0]  src_t;
  typedef logic [31:0] word_t;

endpackage : irq_ctrl_pkg

/* vector_mem.sv */
// Vector table memory with registered read data
`timescale 1ns/1ps

module vector_mem
#(
  parameter int DEPTH = 64,
  parameter int AW    = 6
)
(
  input  wire logic          CLK,
  input  wire logic          WE,
  input  wire logic [AW-1:0] WADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic [AW-1:0] RADDR,
  output logic      [31:0]   RDATA
);

  logic [31:0] mem [DEPTH];

  always_ff @(posedge CLK)
  begin
    if (WE)
    begin
      mem[WADDR] <= WDATA;
    end
  end

  always_ff @(posedge CLK)
  begin
    RDATA <= mem[RADDR];
  end

endmodule : vector_mem

/* vectored_priority_irq_controller.sv */
// Vectored priority interrupt controller with APB register access
`timescale 1ns/1ps
`include "irq_ctrl_params.svh"
// ----------------------------------------------------------------------------
// How it works
// RL1 - Up to 63 sources, 15 priority levels or disabled, one vector each
// RL2 - Falling edge on a source input sets that node's pending flag
// RL3 - Node shows its priority only while enabled and pending, else zero
// RL4 - Encoder picks highest priority; ties go to the lowest source number
// RL5 - Comparator active when running priority is below encoder priority
// RL6 - Global enable plus comparator asserts request, held until acknowledge
// RL7 - Reading the vector base word returns the vector and acknowledges
// RL8 - Acknowledge pushes running priority and adopts the granted one
// RL9 - Acknowledge clears granted pending flag and drops the request
// RL10 - Encoder views show the next pending interrupt right after acknowledge
// RL11 - Writing base plus 0x100 is the exit event
// RL12 - Exit pops the stacked priority back as running priority
// RL13 - Encoder source reads zero when nothing active or comparator idle
// RL14 - Node 0 has no source input; it owns the default vector
// RL15 - Unconnected nodes work as software interrupts via the pending flag
// RL16 - Forced priority raises running level; maximum blocks all requests
// RL17 - A forced raise waits while the request output is asserted
// RL18 - Only acknowledge deasserts an asserted request; standby enable low also clears it here
// RL19 - Node count is a parameter in steps of 8, default 40
// RL20 - Pending flags capture edges with global enable off; stack stays sane
// RL21 - Standby enable low: registers ignore writes; pending still set by hardware
// RL22 - Standby enable low: pending flags are not visible to software
// RL23 - Source edge to request output in at most 2 clock cycles
// RL24 - Vector table base has nine zero LSBs and spans 256 bytes of words
// RL25 - Priority 0 means none, 1 lowest, 15 highest
// RL26 - Pending changes on write only with modify bit set; modify reads zero
// RL27 - Table enable off: no acknowledge, no exit, no vector returned
// RL28 - Vector read returns the table word at base plus four times source; request is active low
// RL29 - Stack holds one priority per nesting level; exit on empty is ignored
// ----------------------------------------------------------------------------

module vectored_priority_irq_controller
#(
  parameter int N_NODES     = `NODES_DEF, // RL19
  parameter int STACK_DEPTH = `STACK_DEPTH_DEF
)
(
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [31:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic [N_NODES-1:0] SRC_IN,
  output logic                    CORE_REQUEST_OUT_N
);

  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam int SIW = $clog2(STACK_DEPTH);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic                  standby_unit_enable_q;
  logic                  unit_rst;
  logic                  global_enable_flag_q;
  logic                  vector_table_enable_q;
  irq_ctrl_pkg::prio_t   forced_priority_q;
  irq_ctrl_pkg::prio_t   forced_eff_q;
  irq_ctrl_pkg::word_t   vector_table_base_q;
  irq_ctrl_pkg::prio_t   aprio_q;
  irq_ctrl_pkg::prio_t   stack_q [STACK_DEPTH];
  logic [SPW-1:0]        sp_q;
  logic                  irq_q;
  logic [N_NODES-1:0]    src_d1_q;
  logic [N_NODES-1:0]    pend_vec;
  logic [N_NODES-1:0]    en_vec;
  irq_ctrl_pkg::prio_t   prio_vec [N_NODES];
  irq_ctrl_pkg::prio_t   node_prio [N_NODES];
  irq_ctrl_pkg::prio_t   enc_prio;
  irq_ctrl_pkg::src_t    enc_idx;
  irq_ctrl_pkg::prio_t   run_prio;
  logic                  comp;
  irq_ctrl_pkg::src_t    encoder_source_view;
  logic                  pready_q;
  logic                  err_q;
  logic                  use_mem_q;
  irq_ctrl_pkg::word_t   rdata_q;
  irq_ctrl_pkg::word_t   mem_rdata;
  irq_ctrl_pkg::src_t    ack_src_q;
  irq_ctrl_pkg::prio_t   ack_prio_q;
  logic                  ack_valid_q;
  logic                  acc_first;
  logic                  done;
  logic                  reg_hit;
  logic                  vt_hit;
  logic                  vt_ack_loc;
  logic                  vt_exit_loc;
  logic                  node_hit;
  irq_ctrl_pkg::src_t    node_idx;
  logic                  reg_ok;
  logic                  wr_ok;
  logic                  wr_reg;
  logic                  wr_node;
  logic                  acknowledge_event;
  logic                  exit_event;
  logic                  mem_we;
  irq_ctrl_pkg::src_t    mem_raddr;
  irq_ctrl_pkg::word_t   reg_rdata;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign acc_first   = PSEL && PENABLE && !pready_q;
  assign done        = PSEL && PENABLE && pready_q;
  assign reg_hit     = (PADDR[31:9] == 23'h000000);
  // The table page sits on a 512-byte boundary and holds 64 words
  assign vt_hit      = !reg_hit && (PADDR[31:9] == vector_table_base_q[31:9]); // RL24
  assign vt_ack_loc  = vt_hit && (PADDR[8:0] == 9'h000);
  assign vt_exit_loc = vt_hit && (PADDR[8:0] == `OFS_EXIT); // RL11
  assign node_hit    = reg_hit && PADDR[8] && (PADDR[1:0] == 2'h0)
                       && (int'(PADDR[7:2]) < N_NODES);
  assign node_idx    = PADDR[7:2];
  assign reg_ok      = node_hit || (reg_hit && (PADDR[8:0] == `OFS_CONTROL
                       || PADDR[8:0] == `OFS_PRIORITY || PADDR[8:0] == `OFS_ENC_PRIO
                       || PADDR[8:0] == `OFS_ENC_SRC || PADDR[8:0] == `OFS_VEC_BASE
                       || PADDR[8:0] == `OFS_STANDBY));
  assign wr_ok       = done && PWRITE && !err_q;
  assign wr_reg      = wr_ok && reg_hit && standby_unit_enable_q; // RL21
  assign wr_node     = wr_reg && node_hit;
  assign acknowledge_event = done && !PWRITE && vt_ack_loc && vector_table_enable_q; // RL7 RL27
  assign exit_event  = wr_ok && vt_exit_loc && vector_table_enable_q; // RL11 RL27
  assign mem_we      = wr_ok && vt_hit && !PADDR[8];
  assign mem_raddr   = (vt_ack_loc && vector_table_enable_q) ? encoder_source_view
                                                             : PADDR[7:2]; // RL28
  assign unit_rst    = RST || !standby_unit_enable_q; // RL21

  // --------------------------------------------------------------------------
  // Source nodes
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
      src_d1_q <= '1;
    else
      src_d1_q <= SRC_IN;
  end

  for (genvar i = 0; i < N_NODES; i++)
  begin : g_node
    logic                source_node_pend_q;
    logic                source_node_en_q;
    irq_ctrl_pkg::prio_t source_node_prio_q;
    logic                hw_edge;

    // Node 0 carries the default vector and takes no input
    assign hw_edge = (i != 0) && src_d1_q[i] && !SRC_IN[i]; // RL2 RL14

    always_ff @(posedge CLK)
    begin
      if (RST)
        source_node_pend_q <= 1'b0;
      else
      begin
        if (wr_node && node_idx == 6'(i) && PWDATA[`BIT_NODE_MODIFY])
          source_node_pend_q <= PWDATA[`BIT_NODE_PEND]; // RL15 RL22 RL26
        else if (acknowledge_event && ack_valid_q && ack_src_q == 6'(i))
          source_node_pend_q <= 1'b0; // RL9
        // Hardware set wins over any clear in the same cycle
        if (hw_edge)
          source_node_pend_q <= 1'b1; // RL2 RL20 RL21
      end
    end

    always_ff @(posedge CLK)
    begin
      if (unit_rst)
      begin
        source_node_en_q   <= 1'b0;
        source_node_prio_q <= '0;
      end
      else if (wr_node && node_idx == 6'(i))
      begin
        source_node_en_q   <= PWDATA[`BIT_NODE_EN];
        source_node_prio_q <= PWDATA[3:0]; // RL1 RL25
      end
    end

    assign pend_vec[i]  = source_node_pend_q;
    assign en_vec[i]    = source_node_en_q;
    assign prio_vec[i]  = source_node_prio_q;
    assign node_prio[i] = (source_node_en_q && source_node_pend_q)
                          ? source_node_prio_q : '0; // RL3
  end

  // --------------------------------------------------------------------------
  // Priority encoder and comparator
  // --------------------------------------------------------------------------
  always_comb
  begin
    enc_prio = '0;
    enc_idx  = '0;
    // Strict compare keeps the lowest number among equals
    for (int k = 0; k < N_NODES; k++)
    begin
      if (node_prio[k] > enc_prio)
      begin
        enc_prio = node_prio[k]; // RL4 RL25
        enc_idx  = 6'(k);
      end
    end
  end

  assign run_prio = (aprio_q > forced_eff_q) ? aprio_q : forced_eff_q; // RL16
  assign comp     = enc_prio > run_prio; // RL5
  assign encoder_source_view = comp ? enc_idx : 6'h00; // RL13 RL10

  // --------------------------------------------------------------------------
  // Request output
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (unit_rst)
      irq_q <= 1'b0;
    else if (acknowledge_event)
      irq_q <= 1'b0; // RL9 RL18
    else if (global_enable_flag_q && comp)
      irq_q <= 1'b1; // RL6 RL20 RL23
  end

  assign CORE_REQUEST_OUT_N = !irq_q; // RL28

  // --------------------------------------------------------------------------
  // Active level logic and its stack
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (unit_rst)
      forced_eff_q <= '0;
    else if (!irq_q)
      forced_eff_q <= forced_priority_q; // RL17
  end

  always_ff @(posedge CLK)
  begin
    if (unit_rst)
    begin
      aprio_q <= '0;
      sp_q    <= '0;
    end
    else if (acknowledge_event && ack_valid_q && int'(sp_q) < STACK_DEPTH)
    begin
      aprio_q <= ack_prio_q; // RL8
      sp_q    <= sp_q + SPW'(1);
    end
    else if (exit_event && sp_q != '0)
    begin
      aprio_q <= stack_q[SIW'(sp_q - SPW'(1))]; // RL12 RL29
      sp_q    <= sp_q - SPW'(1);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!unit_rst && acknowledge_event && ack_valid_q && int'(sp_q) < STACK_DEPTH)
      stack_q[SIW'(sp_q)] <= aprio_q; // RL8 RL29
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
      standby_unit_enable_q <= 1'b0;
    else if (wr_ok && reg_hit && PADDR[8:0] == `OFS_STANDBY)
      standby_unit_enable_q <= PWDATA[`BIT_STANDBY_EN];
  end

  always_ff @(posedge CLK)
  begin
    if (unit_rst)
    begin
      global_enable_flag_q  <= 1'b0;
      vector_table_enable_q <= 1'b0;
      forced_priority_q     <= '0;
      vector_table_base_q   <= `VEC_BASE_RST;
    end
    else if (wr_reg)
    begin
      if (PADDR[8:0] == `OFS_CONTROL)
      begin
        global_enable_flag_q  <= PWDATA[`BIT_GLOBAL_EN];
        vector_table_enable_q <= PWDATA[`BIT_TABLE_EN];
      end
      if (PADDR[8:0] == `OFS_PRIORITY)
        forced_priority_q <= PWDATA[3:0]; // RL16
      if (PADDR[8:0] == `OFS_VEC_BASE)
        vector_table_base_q <= {PWDATA[31:`VEC_BASE_LSBS], 9'h000}; // RL24
    end
  end

  // --------------------------------------------------------------------------
  // Read data and APB answer
  // --------------------------------------------------------------------------
  always_comb
  begin
    reg_rdata = '0;
    if (node_hit)
      reg_rdata = {24'h000000, 1'b0, pend_vec[node_idx] && standby_unit_enable_q,
                   en_vec[node_idx], 1'b0, prio_vec[node_idx]}; // RL22 RL26
    else
      case (PADDR[8:0])
        `OFS_CONTROL:  reg_rdata = {24'h000000, global_enable_flag_q,
                                    vector_table_enable_q, 6'h00};
        `OFS_PRIORITY: reg_rdata = {24'h000000, aprio_q, forced_priority_q};
        `OFS_ENC_PRIO: reg_rdata = {28'h0000000, enc_prio}; // RL10
        `OFS_ENC_SRC:  reg_rdata = {26'h0000000, encoder_source_view}; // RL10
        `OFS_VEC_BASE: reg_rdata = vector_table_base_q;
        `OFS_STANDBY:  reg_rdata = {31'h00000000, standby_unit_enable_q};
        default:       reg_rdata = '0;
      endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      pready_q <= 1'b0;
    else
      pready_q <= acc_first;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      err_q       <= 1'b0;
      use_mem_q   <= 1'b0;
      rdata_q     <= '0;
      ack_src_q   <= '0;
      ack_prio_q  <= '0;
      ack_valid_q <= 1'b0;
    end
    else if (acc_first)
    begin
      err_q       <= !(reg_ok || vt_hit);
      use_mem_q   <= vt_hit && !PADDR[8] && !(vt_ack_loc && !vector_table_enable_q);
      rdata_q     <= reg_hit ? reg_rdata : '0; // RL27
      // The grant is frozen at the first access cycle
      ack_src_q   <= encoder_source_view; // RL7 RL28
      ack_prio_q  <= enc_prio;
      ack_valid_q <= comp;
    end
  end

  assign PREADY  = pready_q;
  assign PSLVERR = pready_q && err_q;
  assign PRDATA  = use_mem_q ? mem_rdata : rdata_q;

  vector_mem #(.DEPTH(`VEC_WORDS), .AW(6)) u_vector_mem
  (
    .CLK   (CLK),
    .WE    (mem_we),
    .WADDR (PADDR[7:2]),
    .WDATA (PWDATA),
    .RADDR (mem_raddr),
    .RDATA (mem_rdata)
  );

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_edge_sets_pend: assert property (src_d1_q[1] && !SRC_IN[1] |=> pend_vec[1]) // RL2
    else $error("falling edge did not set pending");
  a_idle_src_zero: assert property (!comp |-> encoder_source_view == 6'h00) // RL13
    else $error("encoder source not zero while idle");
  a_win_matches: assert property (comp |-> node_prio[enc_idx] == enc_prio
                                   && enc_prio > run_prio) // RL4
    else $error("encoder winner inconsistent");
  a_req_holds: assert property (irq_q && !acknowledge_event && standby_unit_enable_q
                                |=> irq_q) // RL18
    else $error("request dropped without acknowledge");
  a_ack_drops_req: assert property (acknowledge_event && standby_unit_enable_q // RL9
                                    |=> !irq_q && (!ack_valid_q || ack_src_q == 6'h00
                                    || !pend_vec[ack_src_q]
                                    || $past(src_d1_q[ack_src_q] && !SRC_IN[ack_src_q])))
    else $error("acknowledge did not drop request");
  a_req_latency: assert property (global_enable_flag_q && comp && !acknowledge_event
                                  && standby_unit_enable_q |=> irq_q) // RL23
    else $error("request late");
  a_req_needs_enable: assert property ($rose(irq_q) |-> $past(global_enable_flag_q)
                                       && $past(comp)) // RL6
    else $error("request without enable and comparator");
  a_ack_pushes: assert property (acknowledge_event && ack_valid_q && sp_q == '0
                                 && standby_unit_enable_q
                                 |=> sp_q == 1 && aprio_q == $past(ack_prio_q)) // RL8
    else $error("acknowledge did not push priority");
  a_exit_pops: assert property (exit_event && sp_q != '0 && !acknowledge_event
                                && standby_unit_enable_q
                                |=> sp_q == $past(sp_q) - 1'b1) // RL12
    else $error("exit did not pop priority");
  a_standby_quiet: assert property (!standby_unit_enable_q |=> !irq_q
                                    && !global_enable_flag_q) // RL21
    else $error("unit active in standby");

  c_ack:    cover property (acknowledge_event && ack_valid_q);
  c_exit:   cover property (exit_event && sp_q != '0);
  c_nested: cover property (sp_q == 2);
  c_req:    cover property ($rose(irq_q));

endmodule : vectored_priority_irq_controller

/* core_model.sv */
// Core side model: counts request episodes seen at the active-low core input
`timescale 1ns/1ps

module core_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req_n,
  output logic      [31:0] episodes
);
  logic req_n_q;

  // A new episode starts on each fall of the request line
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_n_q  <= 1'b1;
      episodes <= 32'h0;
    end
    else
    begin
      req_n_q <= req_n;
      if (req_n_q && !req_n)
        episodes <= episodes + 32'h1;
    end
  end
endmodule : core_model

/* tb_vectored_priority_irq_controller.sv */
// Self-checking testbench of the vectored priority interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_params.svh"

module tb_vectored_priority_irq_controller;
  localparam logic [31:0] ctl_a  = {23'h0, `OFS_CONTROL};
  localparam logic [31:0] pri_a  = {23'h0, `OFS_PRIORITY};
  localparam logic [31:0] epri_a = {23'h0, `OFS_ENC_PRIO};
  localparam logic [31:0] esrc_a = {23'h0, `OFS_ENC_SRC};
  localparam logic [31:0] vb_a   = `VEC_BASE_RST;
  localparam logic [31:0] vtb_a  = {23'h0, `OFS_VEC_BASE};
  localparam logic [31:0] exit_a = `VEC_BASE_RST + 32'h100;

  logic                clk     = 1'b0;
  logic                rst     = 1'b1;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [31:0]         paddr   = 32'h0;
  logic [31:0]         pwdata  = 32'h0;
  logic [39:0]         src_in  = 40'hff_ffff_ffff;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                req_n;
  logic [31:0]         episodes;
  logic                err_q;
  logic [31:0]         seed    = 32'h0000460a;
  irq_ctrl_pkg::word_t rd;
  irq_ctrl_pkg::word_t vec [40];
  irq_ctrl_pkg::prio_t prio_m [40];
  int                  idx [3];
  int                  error_cnt    = 0;
  int                  total_checks = 0;

  always #25 clk = ~clk;

  vectored_priority_irq_controller vectored_priority_irq_controller_inst
  (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_IN(src_in), .CORE_REQUEST_OUT_N(req_n)
  );

  core_model core_model_inst
  (
    .clk(clk), .rst(rst), .req_n(req_n), .episodes(episodes)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] node(input int n);
    return {23'h0, `OFS_NODE_BASE} + 32'(4 * n);
  endfunction : node

  // Highest priority wins, lowest number on a tie
  function automatic int winner();
    int w;
    w = 0;
    for (int i = 39; i >= 1; i--)
      if (prio_m[i] != 4'h0 && prio_m[i] >= prio_m[w])
        w = i;
    return w;
  endfunction : winner

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request is held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      error_cnt++;
    rd      = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic fall(input int i);
    @(posedge clk);
    src_in[i] <= 1'b0;
    @(posedge clk);
    src_in[i] <= 1'b1;
  endtask : fall

  task automatic ack(input int n);
    rdchk(vb_a, vec[n]);
    @(posedge clk);
    #1 chk(32'(req_n), 32'h1);
  endtask : ack

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    for (int i = 0; i < 40; i++)
      prio_m[i] = 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1 chk(32'(req_n), 32'h1);
    wr(ctl_a, 32'hc0);
    rdchk(ctl_a, 32'h0);
    fall(5);
    rdchk(node(5), 32'h0);
    wr({23'h0, `OFS_STANDBY}, 32'h1);
    rdchk(node(5), 32'h40);
    rdchk(vtb_a, `VEC_BASE_RST);
    apb(1'b0, 32'h18, 32'h0);
    chk(32'(err_q), 32'h1);
    done("reset");
    for (int n = 0; n < 40; n++)
    begin
      vec[n] = xs();
      wr(vb_a + 32'(4 * n), vec[n]);
    end
    wr(vtb_a, 32'h0000_05ff);
    rdchk(vtb_a, 32'h0000_0400);
    rdchk(32'h0000_040c, vec[3]);
    wr(vtb_a, `VEC_BASE_RST);
    wr(ctl_a, 32'hc0);
    wr(node(5), 32'ha3);
    rdchk(node(5), 32'h23);
    @(posedge clk);
    src_in[5] <= 1'b0;
    @(posedge clk);
    src_in[5] <= 1'b1;
    @(posedge clk);
    #1 chk(32'(req_n), 32'h0);
    ack(5);
    rdchk(node(5), 32'h23);
    rdchk(pri_a, 32'h30);
    rdchk(esrc_a, 32'h0);
    wr(node(9), 32'hc6);
    rdchk(epri_a, 32'h0);
    wr(node(9), 32'he6);
    wr(node(7), 32'he6);
    rdchk(esrc_a, 32'h7);
    rdchk(epri_a, 32'h6);
    ack(7);
    rdchk(esrc_a, 32'h0);
    rdchk(epri_a, 32'h6);
    wr(exit_a, 32'h0);
    rdchk(pri_a, 32'h30);
    rdchk(esrc_a, 32'h9);
    ack(9);
    repeat (3) wr(exit_a, 32'h0);
    rdchk(pri_a, 32'h0);
    done("nesting");
    wr(ctl_a, 32'h40);
    fall(5);
    repeat (4) @(posedge clk);
    #1 chk(32'(req_n), 32'h1);
    rdchk(node(5), 32'h63);
    wr(ctl_a, 32'hc0);
    repeat (2) @(posedge clk);
    #1 chk(32'(req_n), 32'h0);
    wr(ctl_a, 32'h40);
    #1 chk(32'(req_n), 32'h0);
    wr(ctl_a, 32'hc0);
    ack(5);
    wr(exit_a, 32'h0);
    wr(pri_a, 32'h0f);
    wr(node(5), 32'he3);
    repeat (4) @(posedge clk);
    #1 chk(32'(req_n), 32'h1);
    wr(pri_a, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk(32'(req_n), 32'h0);
    ack(5);
    wr(exit_a, 32'h0);
    wr(node(5), 32'he3);
    wr(ctl_a, 32'h80);
    rdchk(vb_a, 32'h0);
    #1 chk(32'(req_n), 32'h0);
    wr(ctl_a, 32'hc0);
    ack(5);
    wr(exit_a, 32'h0);
    done("gating");
    for (int k = 0; k < 8; k++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        idx[j] = 1 + int'(xs() % 32'd39);
        prio_m[idx[j]] = 4'h1 + 4'(xs() % 32'd15);
        wr(node(idx[j]), {24'h0, 4'he, prio_m[idx[j]]});
      end
      rdchk(esrc_a, 32'(winner()));
      ack(winner());
      for (int j = 0; j < 3; j++)
      begin
        wr(node(idx[j]), 32'h80);
        prio_m[idx[j]] = 4'h0;
      end
      wr(exit_a, 32'h0);
    end
    done("random");
    chk(episodes, 32'd14);
    final_report();
  end
endmodule : tb_vectored_priority_irq_controller
